// [design/srsq_pkg.sv]
// constants, state codes and timing figures for the switch reset sequencer
// assumes a single 200 MHz core clock; this file needs no other file
package srsq_pkg;

  // core clock rate, in kHz, so that ms figures turn into cycles directly
  localparam int unsigned CLK_KHZ = 200000;

  // longest times after a reset condition clears, in ms
  localparam int unsigned TRAIN_LIMIT_MS = 20;
  localparam int unsigned RETRY_LIMIT_MS = 100;

  // longest times round down; ms times kHz is already whole
  localparam int unsigned TRAIN_LIMIT_CYC = TRAIN_LIMIT_MS * CLK_KHZ;
  localparam int unsigned RETRY_LIMIT_CYC = RETRY_LIMIT_MS * CLK_KHZ;

  // timer counter width, wide enough for the 100 ms window
  localparam int TMR_W = 25;

  // downstream ports behind the switch
  localparam int DS_PORTS = 5;

  // operating mode strap codes; every other code is reserved
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_EEPROM = 4'h1;

  // field widths
  localparam int MODE_W = 4;
  localparam int SLV_ADDR_W = 4;
  localparam int ERR_W = 4;

  // values after reset
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [3:0] SLV_ADDR_RST = 4'h0;
  localparam logic [3:0] ERR_RST = 4'h0;

  // master smbus rate select: high picks the slow 100 kHz rate
  localparam logic MSMB_RATE_100K = 1'b1;
  localparam logic MSMB_RATE_400K = 1'b0;

  // sequencer states
  typedef enum logic [3:0] {
    S_HOLD  = 4'h0, // fundamental reset held, waiting for release
    S_PLL   = 4'h1, // pll and serdes start-up
    S_TRAIN = 4'h2, // stacks released into quasi-reset, training on
    S_SLV   = 4'h3, // slave smbus released
    S_MST   = 4'h4, // master smbus released
    S_EE    = 4'h5, // serial eeprom load
    S_CHK   = 4'h6, // decide halt or run
    S_HALT  = 4'h7, // reset halt, core held; smbus, registers and training stacks in quasi-reset alive
    S_NORM  = 4'h8, // normal operation
    S_HOT   = 4'h9  // hot reset pulse
  } srsq_state_type;

endpackage

// [design/srsq_sequencer.sv]
// reset sequencer for a multi-port pcie switch: fundamental, hot and
// secondary bus resets, boot strap capture, smbus and eeprom bring-up
// assumes all inputs synchronous to ref_clk; request inputs are pulses
`timescale 1ns/1ps
`default_nettype none
module srsq_sequencer #(
  parameter int unsigned TRAIN_CYCLES = srsq_pkg::TRAIN_LIMIT_CYC,
  parameter int unsigned RETRY_CYCLES = srsq_pkg::RETRY_LIMIT_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic fundamental_reset_n,
  input wire logic warm_reset_request,
  input wire logic hot_reset_request,
  input wire logic [3:0] operating_mode_strap,
  input wire logic master_smbus_slow_strap,
  input wire logic [3:0] slave_smbus_addr_strap,
  input wire logic reset_halt_pin,
  input wire logic pll_lock,
  input wire logic stack_ready,
  input wire logic ts1_hot_reset_rx,
  input wire logic upstream_dl_down,
  input wire logic link_down_hot_reset_disable,
  input wire logic hot_reset_eeprom_load_disable,
  input wire logic eeprom_load_finish,
  input wire logic eeprom_load_error,
  input wire logic [3:0] eeprom_error_code,
  input wire logic reset_halt_clear,
  input wire logic upstream_sbr_bit,
  input wire logic [4:0] ds_sbr_bit,
  input wire logic [4:0] ds_link_up,
  output logic write_cpl_r,
  output logic [3:0] latched_mode_r,
  output logic pll_init_r,
  output logic stack_reset_n_r,
  output logic quasi_reset_r,
  output logic cfg_retry_r,
  output logic links_train_r,
  output logic core_reset_n_r,
  output logic nonsticky_clear_r,
  output logic regs_in_reset_r,
  output logic gpio_force_input_r,
  output logic slave_smbus_rst_n_r,
  output logic [3:0] slave_smbus_addr_r,
  output logic master_smbus_rst_n_r,
  output logic master_smbus_slow_r,
  output logic eeprom_load_start_r,
  output logic eeprom_load_done_r,
  output logic [3:0] eeprom_err_code_r,
  output logic reset_halt_ctl_r,
  output logic reset_halt_flag_r,
  output logic normal_op_r,
  output logic [4:0] ds_hot_ts1_r,
  output logic [4:0] ds_tlp_flush_r,
  output logic [4:0] ds_port_reset_r,
  output logic [4:0] ds_secondary_ur_r,
  output logic us_secondary_ur_r
);

  srsq_pkg::srsq_state_type state_r, state_nxt;
  logic pin_cause_r;
  logic hot_path_r;
  logic slow_vec_r;
  logic [3:0] addr_vec_r;
  logic halt_vec_r;
  logic warm_pend_r;
  logic hot_pend_r;
  logic sw_window;
  logic hot_ev;
  logic ee_needed;
  logic tmr_start;
  logic train_exp;
  logic retry_exp;
  logic stack_live;
  logic [4:0] ds_sbr_prev_r;

  // software reaches the control register only once logic is running
  assign sw_window = (state_r == srsq_pkg::S_NORM) ||
                     (state_r == srsq_pkg::S_HALT);
  assign hot_ev = ts1_hot_reset_rx ||
                  (upstream_dl_down && !link_down_hot_reset_disable);
  // reserved modes behave as plain normal mode
  assign ee_needed = (latched_mode_r == srsq_pkg::MODE_EEPROM) &&
                     (!hot_path_r || !hot_reset_eeprom_load_disable);
  // both windows open when the reset condition clears
  assign tmr_start = ((state_r == srsq_pkg::S_HOLD) ||
                      (state_r == srsq_pkg::S_HOT)) &&
                     (state_nxt != state_r);
  assign stack_live = (state_nxt == srsq_pkg::S_TRAIN) ||
                      (state_nxt == srsq_pkg::S_SLV) ||
                      (state_nxt == srsq_pkg::S_MST) ||
                      (state_nxt == srsq_pkg::S_EE) ||
                      (state_nxt == srsq_pkg::S_CHK) ||
                      (state_nxt == srsq_pkg::S_HALT) ||
                      (state_nxt == srsq_pkg::S_NORM);

  srsq_timer #(.CYCLES(TRAIN_CYCLES)) train_tmr (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(tmr_start),
    .expired_r(train_exp)
  );

  srsq_timer #(.CYCLES(RETRY_CYCLES)) retry_tmr (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(tmr_start),
    .expired_r(retry_exp)
  );

  // next state; the pin outranks everything, then a completed write
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      srsq_pkg::S_HOLD: begin
        if (fundamental_reset_n) state_nxt = srsq_pkg::S_PLL;
      end
      srsq_pkg::S_PLL: begin
        // a slow pll must not push training past its deadline
        if (pll_lock || train_exp) state_nxt = srsq_pkg::S_TRAIN;
      end
      srsq_pkg::S_TRAIN: begin
        if (!hot_path_r) state_nxt = srsq_pkg::S_SLV;
        else if (ee_needed) state_nxt = srsq_pkg::S_EE;
        else state_nxt = srsq_pkg::S_CHK;
      end
      srsq_pkg::S_SLV: state_nxt = srsq_pkg::S_MST;
      srsq_pkg::S_MST: begin
        if (ee_needed) state_nxt = srsq_pkg::S_EE;
        else state_nxt = srsq_pkg::S_CHK;
      end
      srsq_pkg::S_EE: begin
        if (eeprom_load_finish || eeprom_load_error) begin
          state_nxt = srsq_pkg::S_CHK;
        end
      end
      srsq_pkg::S_CHK: begin
        if (reset_halt_ctl_r) state_nxt = srsq_pkg::S_HALT;
        else state_nxt = srsq_pkg::S_NORM;
      end
      srsq_pkg::S_HALT: begin
        if (!reset_halt_ctl_r) state_nxt = srsq_pkg::S_NORM;
      end
      srsq_pkg::S_NORM: state_nxt = srsq_pkg::S_NORM;
      srsq_pkg::S_HOT: state_nxt = srsq_pkg::S_TRAIN;
      default: state_nxt = srsq_pkg::S_HOLD;
    endcase
    if (write_cpl_r && warm_pend_r) begin
      state_nxt = srsq_pkg::S_HOLD;
    end else if ((write_cpl_r && hot_pend_r) || (hot_ev && sw_window)) begin
      state_nxt = srsq_pkg::S_HOT;
    end
    if (!fundamental_reset_n) state_nxt = srsq_pkg::S_HOLD;
  end

  // state register; power-on lands in the held fundamental reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) state_r <= srsq_pkg::S_HOLD;
    else state_r <= state_nxt;
  end

  // remember why we are in fundamental reset; only the pin resamples
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_cause_r <= 1'b1;
      hot_path_r <= 1'b0;
    end else begin
      if (!fundamental_reset_n) pin_cause_r <= 1'b1;
      else if (state_r == srsq_pkg::S_PLL) pin_cause_r <= 1'b0;
      if (state_nxt == srsq_pkg::S_HOT) hot_path_r <= 1'b1;
      else if (state_nxt == srsq_pkg::S_HOLD) hot_path_r <= 1'b0;
    end
  end

  // boot vector capture on release of the pin, kept for software resets
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      latched_mode_r <= srsq_pkg::MODE_RST;
      slow_vec_r <= srsq_pkg::MSMB_RATE_400K;
      addr_vec_r <= srsq_pkg::SLV_ADDR_RST;
      halt_vec_r <= 1'b0;
    end else if ((state_r == srsq_pkg::S_HOLD) && fundamental_reset_n &&
                 pin_cause_r) begin
      latched_mode_r <= operating_mode_strap;
      slow_vec_r <= master_smbus_slow_strap;
      addr_vec_r <= slave_smbus_addr_strap;
      halt_vec_r <= reset_halt_pin;
    end
  end

  // reset-causing writes: answer first, reset on the following cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      write_cpl_r <= 1'b0;
      warm_pend_r <= 1'b0;
      hot_pend_r <= 1'b0;
    end else begin
      write_cpl_r <= sw_window && (warm_reset_request || hot_reset_request);
      warm_pend_r <= sw_window && warm_reset_request;
      hot_pend_r <= sw_window && hot_reset_request && !warm_reset_request;
    end
  end

  // reset fan-out to the core, stacks and plls
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pll_init_r <= 1'b0;
      stack_reset_n_r <= 1'b0;
      quasi_reset_r <= 1'b0;
      links_train_r <= 1'b0;
      core_reset_n_r <= 1'b0;
      normal_op_r <= 1'b0;
      nonsticky_clear_r <= 1'b0;
      regs_in_reset_r <= 1'b1;
      gpio_force_input_r <= 1'b1;
    end else begin
      pll_init_r <= (state_nxt == srsq_pkg::S_PLL);
      stack_reset_n_r <= stack_live;
      quasi_reset_r <= stack_live && (state_nxt != srsq_pkg::S_NORM);
      links_train_r <= stack_live;
      core_reset_n_r <= (state_nxt == srsq_pkg::S_NORM);
      normal_op_r <= (state_nxt == srsq_pkg::S_NORM);
      nonsticky_clear_r <= (state_nxt == srsq_pkg::S_HOT);
      // register file reachable again once the stacks come back
      regs_in_reset_r <= !stack_live;
      gpio_force_input_r <= (state_nxt == srsq_pkg::S_HOLD);
    end
  end

  // config retry answers open on stack readiness, at the latest at 100 ms
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) cfg_retry_r <= 1'b0;
    else cfg_retry_r <= stack_live && (state_nxt != srsq_pkg::S_NORM) &&
                        (cfg_retry_r || stack_ready || retry_exp);
  end

  // smbus bring-up; hot reset leaves both interfaces running
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      slave_smbus_rst_n_r <= 1'b0;
      slave_smbus_addr_r <= srsq_pkg::SLV_ADDR_RST;
      master_smbus_rst_n_r <= 1'b0;
      master_smbus_slow_r <= srsq_pkg::MSMB_RATE_400K;
    end else if (state_nxt == srsq_pkg::S_HOLD) begin
      slave_smbus_rst_n_r <= 1'b0;
      master_smbus_rst_n_r <= 1'b0;
    end else begin
      if (state_nxt == srsq_pkg::S_SLV) begin
        slave_smbus_rst_n_r <= 1'b1;
        slave_smbus_addr_r <= addr_vec_r;
      end
      if ((state_nxt == srsq_pkg::S_MST) && slave_smbus_rst_n_r) begin
        master_smbus_rst_n_r <= 1'b1;
        master_smbus_slow_r <= slow_vec_r ? srsq_pkg::MSMB_RATE_100K :
                               srsq_pkg::MSMB_RATE_400K;
      end
    end
  end

  // eeprom load handshake; done also covers an aborted load
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      eeprom_load_start_r <= 1'b0;
      eeprom_load_done_r <= 1'b0;
      eeprom_err_code_r <= srsq_pkg::ERR_RST;
    end else begin
      eeprom_load_start_r <= (state_r != srsq_pkg::S_EE) &&
                             (state_nxt == srsq_pkg::S_EE);
      if ((state_r != srsq_pkg::S_EE) && (state_nxt == srsq_pkg::S_EE)) begin
        eeprom_load_done_r <= 1'b0;
      end else if ((state_r == srsq_pkg::S_EE) &&
                   (eeprom_load_finish || eeprom_load_error)) begin
        eeprom_load_done_r <= 1'b1;
      end
      if ((state_r == srsq_pkg::S_EE) && eeprom_load_error) begin
        eeprom_err_code_r <= eeprom_error_code;
      end
    end
  end

  // halt control and status; a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reset_halt_ctl_r <= 1'b0;
      reset_halt_flag_r <= 1'b0;
    end else begin
      if ((state_r == srsq_pkg::S_TRAIN) && !hot_path_r && halt_vec_r) begin
        reset_halt_ctl_r <= 1'b1;
        reset_halt_flag_r <= 1'b1;
      end else if ((state_r == srsq_pkg::S_EE) && eeprom_load_error) begin
        reset_halt_ctl_r <= 1'b1;
      end else if ((state_nxt == srsq_pkg::S_HOLD) ||
                   (state_nxt == srsq_pkg::S_HOT)) begin
        reset_halt_ctl_r <= 1'b0;
        if (state_nxt == srsq_pkg::S_HOLD) reset_halt_flag_r <= 1'b0;
      end else if (reset_halt_clear) begin
        reset_halt_ctl_r <= 1'b0;
      end
    end
  end

  // upstream secondary reset: the upstream port itself stays up
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      us_secondary_ur_r <= 1'b0;
    end else begin
      us_secondary_ur_r <= upstream_sbr_bit && normal_op_r;
    end
  end

  // per-port secondary resets; a hot reset hits every linked port
  genvar gi;
  generate
    for (gi = 0; gi < srsq_pkg::DS_PORTS; gi++) begin : g_port
      logic sbr_now;
      logic sbr_rise;
      assign sbr_now = normal_op_r && (ds_sbr_bit[gi] || upstream_sbr_bit);
      assign sbr_rise = sbr_now && !ds_sbr_prev_r[gi];
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          ds_sbr_prev_r[gi] <= 1'b0;
          ds_hot_ts1_r[gi] <= 1'b0;
          ds_tlp_flush_r[gi] <= 1'b0;
          ds_port_reset_r[gi] <= 1'b0;
          ds_secondary_ur_r[gi] <= 1'b0;
        end else begin
          ds_sbr_prev_r[gi] <= sbr_now;
          ds_hot_ts1_r[gi] <= ds_link_up[gi] &&
                              (sbr_rise || (state_nxt == srsq_pkg::S_HOT));
          ds_tlp_flush_r[gi] <= sbr_rise;
          // graceful port reset lasts until software clears the bit
          ds_port_reset_r[gi] <= sbr_now;
          ds_secondary_ur_r[gi] <= normal_op_r && ds_sbr_bit[gi];
        end
      end
    end
  endgenerate

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  pin_hold_a: assert property (!fundamental_reset_n |=>
    state_r == srsq_pkg::S_HOLD && !core_reset_n_r)
    else $error("pin low did not hold fundamental reset");

  vec_latch_a: assert property (
    state_r == srsq_pkg::S_HOLD && fundamental_reset_n && pin_cause_r |=>
    latched_mode_r == $past(operating_mode_strap))
    else $error("mode strap not captured on release");

  smb_order_a: assert property ($rose(master_smbus_rst_n_r) |->
    slave_smbus_rst_n_r && $past(slave_smbus_rst_n_r))
    else $error("master smbus released before slave");

  smb_rate_a: assert property ($rose(master_smbus_rst_n_r) |->
    master_smbus_slow_r == slow_vec_r)
    else $error("master smbus rate does not follow strap");

  ee_error_a: assert property (
    state_r == srsq_pkg::S_EE && eeprom_load_error && fundamental_reset_n &&
    !write_cpl_r |=> eeprom_load_done_r && reset_halt_ctl_r ##1
    state_r == srsq_pkg::S_HALT)
    else $error("eeprom error not turned into halt");

  cpl_first_a: assert property (
    warm_reset_request && sw_window && fundamental_reset_n |=>
    write_cpl_r && state_r != srsq_pkg::S_HOLD)
    else $error("reset began before completion");

  dl_mask_a: assert property (
    state_r == srsq_pkg::S_NORM && upstream_dl_down &&
    link_down_hot_reset_disable && !ts1_hot_reset_rx && !write_cpl_r &&
    fundamental_reset_n |=> state_r == srsq_pkg::S_NORM)
    else $error("masked link down caused hot reset");

  halt_hold_a: assert property (
    state_r == srsq_pkg::S_HALT |-> !core_reset_n_r && quasi_reset_r)
    else $error("core left reset while halted");

  train_on_a: assert property (state_r == srsq_pkg::S_SLV |->
    links_train_r && stack_reset_n_r && $past(pll_init_r, 2))
    else $error("smbus bring-up before training began");

  ds_reset_a: assert property (
    normal_op_r && (ds_sbr_bit[3] || upstream_sbr_bit) &&
    !ds_sbr_prev_r[3] |=> ds_tlp_flush_r[3] ##1 !ds_tlp_flush_r[3])
    else $error("port flush not a single pulse");

endmodule // srsq_sequencer
`default_nettype wire

// [design/srsq_timer.sv]
// one-shot down-counter that flags expiry of a fixed window
// assumes start is a one-cycle pulse; a new start restarts the window
`timescale 1ns/1ps
`default_nettype none
module srsq_timer #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic start,
  output logic expired_r
);

  logic [srsq_pkg::TMR_W-1:0] count_r;
  logic armed_r;

  // count down from one less than the window length; expiry holds until restart
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_r <= '0;
      armed_r <= 1'b0;
      expired_r <= 1'b0;
    end else if (start) begin
      count_r <= srsq_pkg::TMR_W'(CYCLES - 1);
      armed_r <= 1'b1;
      expired_r <= 1'b0;
    end else if (armed_r) begin
      if (count_r == '0) begin
        armed_r <= 1'b0;
        expired_r <= 1'b1;
      end else begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule // srsq_timer
`default_nettype wire

// [testbench/srsq_far_model.sv]
// far side of the sequencer: plls, stacks and serial eeprom loader
// assumes straps and requests come from the bench; slow/err chosen by it
`timescale 1ns/1ps
`default_nettype none
module srsq_far_model #(
  parameter logic [3:0] ERR_CODE = 4'h6 // arbitrary error code
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic pll_init_r,
  input wire logic quasi_reset_r,
  input wire logic eeprom_load_start_r,
  input wire logic slow,
  input wire logic err,
  output logic pll_lock,
  output logic stack_ready,
  output logic eeprom_load_finish,
  output logic eeprom_load_error,
  output logic [3:0] eeprom_error_code
);
  int pll_cnt, stk_cnt, ee_cnt, lim;
  assign lim = slow ? 30 : 5;
  // slow lock and slow stacks force the design's own windows to cut in
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pll_cnt <= 0;
      stk_cnt <= 0;
      pll_lock <= 1'h0;
      stack_ready <= 1'h0;
    end else begin
      pll_cnt <= pll_init_r ? pll_cnt + 1 : 0;
      stk_cnt <= quasi_reset_r ? stk_cnt + 1 : 0;
      pll_lock <= pll_init_r && pll_cnt >= (slow ? 40 : 3);
      stack_ready <= quasi_reset_r && stk_cnt >= (slow ? 80 : 4);
    end
  end
  // load ends a fixed time after start, well inside the limit
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ee_cnt <= 0;
      eeprom_load_finish <= 1'h0;
      eeprom_load_error <= 1'h0;
    end else begin
      ee_cnt <= eeprom_load_start_r ? 1 :
        (ee_cnt != 0 && ee_cnt < lim) ? ee_cnt + 1 : 0;
      eeprom_load_finish <= ee_cnt == lim && !err;
      eeprom_load_error <= ee_cnt == lim && err;
    end
  end
  // code only valid with the error pulse; otherwise show its inverse
  assign eeprom_error_code = eeprom_load_error ? ERR_CODE : ~ERR_CODE;
endmodule // srsq_far_model
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the reset sequencer with its far side model
// assumes design files and srsq_far_model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TR = 20;
  localparam int RT = 50;
  localparam logic [3:0] EC = 4'h6;
  logic ref_clk = 1'h0, resetn = 1'h0, fundamental_reset_n = 1'h1;
  logic warm_reset_request = 1'h0, hot_reset_request = 1'h0;
  logic [3:0] operating_mode_strap = 4'h1, slave_smbus_addr_strap = 4'hA;
  logic master_smbus_slow_strap = 1'h1, reset_halt_pin = 1'h0;
  logic pll_lock, stack_ready, eeprom_load_finish, eeprom_load_error;
  logic [3:0] eeprom_error_code;
  logic ts1_hot_reset_rx = 1'h0, upstream_dl_down = 1'h0;
  logic reset_halt_clear = 1'h0, upstream_sbr_bit = 1'h0;
  logic link_down_hot_reset_disable = 1'h0;
  logic hot_reset_eeprom_load_disable = 1'h0;
  logic slow = 1'h1, err = 1'h0;
  logic [4:0] ds_sbr_bit = 5'h00, ds_link_up = 5'h1F;
  logic write_cpl_r, pll_init_r, stack_reset_n_r, quasi_reset_r;
  logic cfg_retry_r, links_train_r, core_reset_n_r, nonsticky_clear_r;
  logic regs_in_reset_r, gpio_force_input_r, slave_smbus_rst_n_r;
  logic master_smbus_rst_n_r, master_smbus_slow_r, eeprom_load_start_r;
  logic eeprom_load_done_r, reset_halt_ctl_r, reset_halt_flag_r;
  logic normal_op_r, us_secondary_ur_r;
  logic [3:0] latched_mode_r, slave_smbus_addr_r, eeprom_err_code_r;
  logic [4:0] ds_hot_ts1_r, ds_tlp_flush_r, ds_port_reset_r;
  logic [4:0] ds_secondary_ur_r, s_ts1, s_fl;
  logic s_st, s_nsc, s_norm, s_gpio, s_mlow, cpl_ok;
  int cyc = 0, t_rel, n_mismatch = 0, n_compared = 0;
  int t [5];
  // a clr request is a count, so only the record process writes records
  int clr_req = 0, clr_ack = 0;
  logic fresh;
  logic [4:0] rise_src;
  assign fresh = clr_req != clr_ack;
  assign rise_src = {master_smbus_rst_n_r, slave_smbus_rst_n_r, cfg_retry_r,
                     links_train_r, pll_init_r};
  srsq_sequencer #(.TRAIN_CYCLES(TR), .RETRY_CYCLES(RT)) dut (.*);
  srsq_far_model #(.ERR_CODE(EC)) far (.*);
  always #2.5 ref_clk = ~ref_clk;
  // sticky pulse records and first-rise times; a clr request restarts them
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    clr_ack <= clr_req;
    s_ts1 <= (fresh ? 5'h00 : s_ts1) | ds_hot_ts1_r;
    s_fl <= (fresh ? 5'h00 : s_fl) | ds_tlp_flush_r;
    s_st <= (!fresh & s_st) | eeprom_load_start_r;
    s_nsc <= (!fresh & s_nsc) | nonsticky_clear_r;
    s_norm <= (!fresh & s_norm) | normal_op_r;
    s_gpio <= (!fresh & s_gpio) | gpio_force_input_r;
    s_mlow <= (!fresh & s_mlow) | !master_smbus_rst_n_r;
    cpl_ok <= (!fresh & cpl_ok) | (write_cpl_r & core_reset_n_r);
    for (int i = 0; i < 5; i++) begin
      if (rise_src[i] && (fresh || t[i] == 0)) t[i] <= cyc;
      else if (fresh) t[i] <= 0;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic clr;
    clr_req++;
    t_rel = cyc;
  endtask
  // 0: normal op, 1: master smbus out of reset, 2: eeprom done
  task automatic wait_for(input int sel);
    for (int i = 0; i < 3000; i++) begin
      if (sel == 0 && normal_op_r === 1'h1) return;
      if (sel == 1 && master_smbus_rst_n_r === 1'h1) return;
      if (sel == 2 && eeprom_load_done_r === 1'h1) return;
      tick(1);
    end
    n_mismatch++;
    $display("wrong value at %0t: wait ran out", $time);
    summarize();
  endtask
  task automatic fund;
    fundamental_reset_n = 1'h0;
    tick(3);
    chk(gpio_force_input_r, 1'h1);
    chk(master_smbus_rst_n_r, 1'h0);
    chk(regs_in_reset_r, 1'h1);
    fundamental_reset_n = 1'h1;
    clr();
  endtask
  task automatic unhalt;
    reset_halt_clear = 1'h1;
    tick(1);
    reset_halt_clear = 1'h0;
    wait_for(0);
  endtask
  initial begin
    clr();
    tick(6);
    chk(gpio_force_input_r, 1'h1);
    chk(core_reset_n_r, 1'h0);
    resetn = 1'h1;
    clr();
    wait_for(0);
    chk(latched_mode_r, srsq_pkg::MODE_EEPROM);
    chk(master_smbus_slow_r, srsq_pkg::MSMB_RATE_100K);
    chk(slave_smbus_addr_r, 4'hA);
    chk({s_st, eeprom_load_done_r}, 2'h3);
    chk(t[3] < t[4], 1'h1);
    chk(t[0] < t[1] && t[1] <= t[3], 1'h1);
    chk(t[1] > 0 && t[1] - t_rel <= TR + 5, 1'h1);
    chk(t[2] > 0 && t[2] - t_rel <= RT + 5, 1'h1);
    // software warm reset must keep the old straps
    slow = 1'h0;
    operating_mode_strap = 4'h0;
    master_smbus_slow_strap = 1'h0;
    slave_smbus_addr_strap = 4'h5;
    clr();
    warm_reset_request = 1'h1;
    tick(1);
    warm_reset_request = 1'h0;
    tick(3);
    wait_for(0);
    chk({cpl_ok, s_gpio}, 2'h3);
    chk({latched_mode_r, slave_smbus_addr_r}, 8'h1A);
    // pin reset with halt strap takes new straps and stops in halt
    reset_halt_pin = 1'h1;
    fund();
    wait_for(1);
    tick(40);
    chk({s_norm, s_st, reset_halt_flag_r}, 3'h1);
    chk({regs_in_reset_r, quasi_reset_r, stack_reset_n_r, core_reset_n_r},
        4'h6);
    chk({latched_mode_r, slave_smbus_addr_r}, 8'h05);
    chk(master_smbus_slow_r, srsq_pkg::MSMB_RATE_400K);
    reset_halt_pin = 1'h0;
    unhalt();
    // eeprom error aborts into halt with its code kept
    operating_mode_strap = 4'h1;
    err = 1'h1;
    fund();
    wait_for(2);
    tick(20);
    chk({eeprom_err_code_r, reset_halt_ctl_r, s_norm}, {EC, 2'h2});
    err = 1'h0;
    unhalt();
    // masked link down, then ts1, link down and write triggers
    ds_link_up = 5'h12;
    for (int k = 0; k < 4; k++) begin
      link_down_hot_reset_disable = k == 0;
      hot_reset_eeprom_load_disable = k == 2;
      clr();
      ts1_hot_reset_rx = k == 1;
      upstream_dl_down = k == 0 || k == 2;
      hot_reset_request = k == 3;
      tick(1);
      {ts1_hot_reset_rx, upstream_dl_down, hot_reset_request} = 3'h0;
      tick(3);
      wait_for(0);
      chk(s_nsc, k != 0);
      chk(s_ts1, k != 0 ? 5'h12 : 5'h00);
      chk(s_st, k == 1 || k == 3);
      chk({s_mlow, cpl_ok}, k == 3);
    end
    // secondary reset of port 3 leaves the others alone
    ds_link_up = 5'h0B;
    clr();
    ds_sbr_bit = 5'h08;
    tick(3);
    chk({s_fl, s_ts1, ds_port_reset_r}, 15'h2108);
    chk({ds_secondary_ur_r, us_secondary_ur_r}, 6'h10);
    ds_sbr_bit = 5'h00;
    tick(3);
    chk(ds_port_reset_r, 5'h00);
    clr();
    upstream_sbr_bit = 1'h1;
    tick(3);
    chk({s_ts1, s_fl}, 10'h17F);
    chk({us_secondary_ur_r, normal_op_r}, 2'h3);
    upstream_sbr_bit = 1'h0;
    tick(3);
    chk(ds_port_reset_r, 5'h00);
    // reserved mode code runs as plain normal mode, no eeprom load
    operating_mode_strap = 4'hC;
    fund();
    wait_for(0);
    chk({latched_mode_r, s_st, reset_halt_flag_r}, 6'h30);
    summarize();
  end
endmodule // tb
`default_nettype wire
